// ### rx_pkg.sv
// Constants, types and helper functions for the four-channel resolver interface.
// Operation
// RQ1 - Excitation control: 32 bits, upper 12 used
// RQ2 - One excitation waveform serves all four channels
// RQ3 - Top 8 bits: phase shift, 1/512 cycle
// RQ4 - Sample sine and cosine on phase clock rise
// RQ5 - Magnitude code gives 1/4, 1/2, 3/4, full
// RQ6 - Frequency code divides phase clock by 1,2,4,6
// RQ7 - Sum of squares computed each phase cycle
// RQ8 - Direction sense from encoder control bit 2
// RQ9 - Add sine and cosine offsets before arctangent
// RQ10 - Result upper half: angle, 65536 per cycle
// RQ11 - Result lower half: sum-of-squares magnitude
// RQ12 - Top four magnitude bits zero sets loss
// RQ13 - Software keeps magnitude at or below 32767
// RQ14 - Angle at result address, magnitude separately
// RQ15 - Loss flag is status register bit 31
// RQ16 - Both result halves update together
package rx_pkg;

	localparam int RX_CHANNELS = 4;
	localparam int RX_CORDIC_STEPS = 14;

	// Register map, byte addresses
	localparam logic [11:0] RX_ADDR_EXC = 12'h000;
	localparam logic [11:0] RX_ADDR_IRQ_STAT = 12'h004;
	localparam logic [11:0] RX_ADDR_IRQ_MASK = 12'h008;
	localparam logic [4:0] RX_CH_SEL = 5'h01;
	localparam int RX_CH_SEL_LSB = 7;
	localparam int RX_CH_IDX_LSB = 5;
	localparam logic [4:0] RX_REG_ENC = 5'h00;
	localparam logic [4:0] RX_REG_SOFF = 5'h04;
	localparam logic [4:0] RX_REG_COFF = 5'h08;
	localparam logic [4:0] RX_REG_RESULT = 5'h0C;
	localparam logic [4:0] RX_REG_STATUS = 5'h10;
	localparam logic [4:0] RX_REG_SOS = 5'h14;

	// Field layout
	localparam int RX_EXC_USED_LSB = 20;
	localparam int RX_SHIFT_LSB = 24;
	localparam int RX_GAIN_LSB = 22;
	localparam int RX_FREQ_LSB = 20;
	localparam int RX_DIR_BIT = 2;
	localparam int RX_LOSS_BIT = 31;
	localparam int RX_IRQ_DONE_BIT = 4;
	localparam int RX_SOS_SHIFT = 15;
	localparam logic [31:0] RX_ENC_RESET = 32'h0000_0007;
	localparam logic [11:0] RX_EXC_RESET = 12'h000;
	localparam logic [19:0] RX_STEPS_PER_CYCLE = 20'h00200;
	localparam logic [15:0] RX_HALF_TURN = 16'h8000;

	// atan(2^-i) in 1/65536 of a turn
	localparam logic [15:0] RX_ATAN [0:RX_CORDIC_STEPS-1] = '{
		16'h2000, 16'h12E4, 16'h09FB, 16'h0511, 16'h028B, 16'h0146, 16'h00A3,
		16'h0051, 16'h0029, 16'h0014, 16'h000A, 16'h0005, 16'h0003, 16'h0001};

	// Quarter sine, 16 points, entry k at bits [16k+15:16k]
	localparam logic [255:0] RX_QSINE = {
		16'h7FD8, 16'h7E9D, 16'h7C29, 16'h7883, 16'h73B5, 16'h6DC9, 16'h66CF, 16'h5ED7,
		16'h55F6, 16'h4C40, 16'h41CE, 16'h36BA, 16'h2B1F, 16'h1F1A, 16'h12C8, 16'h0648};

	typedef struct packed {
		logic signed [15:0] sine;
		logic signed [15:0] cosine;
	} rx_adc_pair_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_LOAD = 2'b01,
		RX_ITER = 2'b11,
		RX_STORE = 2'b10
	} rx_state_t;

	function automatic logic [2:0] rx_freq_div(input logic [1:0] code);
		case (code)
			2'h0: rx_freq_div = 3'h1;
			2'h1: rx_freq_div = 3'h2;
			2'h2: rx_freq_div = 3'h4;
			default: rx_freq_div = 3'h6;
		endcase
	endfunction

	function automatic logic signed [15:0] rx_sine(input logic [8:0] ang);
		logic [3:0] idx;
		logic [15:0] mag;
		idx = ang[7] ? ~ang[6:3] : ang[6:3];
		mag = RX_QSINE[{idx, 4'h0} +: 16];
		rx_sine = ang[8] ? -$signed(mag) : $signed(mag);
	endfunction

	function automatic logic signed [15:0] rx_sat_add(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [16:0] s;
		s = {a[15], a} + {b[15], b};
		if (s[16] != s[15])
			rx_sat_add = s[16] ? 16'sh8000 : 16'sh7FFF;
		else
			rx_sat_add = s[15:0];
	endfunction

endpackage

// ### rx_resolver.sv
// Four-channel resolver interface: excitation, offset correction, arctangent, loss check.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module rx_resolver import rx_pkg::*; (
	input wire logic clk, // 100 MHz system clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic phase_clk, // Phase clock pin
	input wire rx_adc_pair_t [RX_CHANNELS-1:0] adc_in, // Sine and cosine ADC codes
	output logic signed [15:0] exc_out, // Shared excitation sample
	output logic irq // Level interrupt
);

	logic [11:0] exc_ctrl;
	logic [31:0] enc_ctrl [RX_CHANNELS];
	logic [31:0] sin_off [RX_CHANNELS];
	logic [31:0] cos_off [RX_CHANNELS];
	logic [31:0] result [RX_CHANNELS];
	logic [RX_CHANNELS-1:0] loss;
	logic [4:0] irq_stat;
	logic [4:0] irq_mask;
	logic [4:0] irq_set;
	logic [4:0] rd_snap;

	logic [2:0] ph_sync;
	logic phase_rise;
	rx_adc_pair_t [RX_CHANNELS-1:0] adc_s1, adc_s2, samp;

	logic [15:0] period_cnt, period;
	logic [2:0] ph_idx;
	logic [19:0] acc;
	logic [8:0] base;

	rx_state_t state;
	logic [1:0] ch;
	logic [3:0] it;
	logic signed [19:0] cx, cy;
	logic [15:0] cz;
	logic [15:0] sos_hold;
	logic [15:0] angle;
	// Guard bits keep the truncating shifts from eroding small signals
	localparam int RX_GUARD_BITS = 2;
	// With no signal at all the engine would drift to a meaningless angle; report zero
	assign angle = (cx == 20'sh00000) ? 16'h0000 : cz;

	logic setup, access, wr, rd;
	logic [1:0] a_ch;
	logic [4:0] a_reg;
	logic a_chan;
	logic [31:0] next_rdata;
	logic next_err;

	// Phase clock and ADC pins are asynchronous: two flops before use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_sync <= 3'h0;
			adc_s1 <= '0;
			adc_s2 <= '0;
		end else begin
			ph_sync <= {ph_sync[1:0], phase_clk};
			adc_s1 <= adc_in;
			adc_s2 <= adc_s1;
		end
	end
	assign phase_rise = ph_sync[1] & ~ph_sync[2];

	// Samples held while a sweep runs so one sweep uses one consistent set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			samp <= '0;
		else if (phase_rise && state == RX_IDLE)
			samp <= adc_s2; // see RQ4
	end

	// Phase period measured in clk cycles, used to pace the excitation
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			period_cnt <= 16'h0000;
			period <= 16'hFFFF;
		end else if (phase_rise) begin
			period <= period_cnt + 16'h0001;
			period_cnt <= 16'h0000;
		end else if (period_cnt != 16'hFFFF) begin
			period_cnt <= period_cnt + 16'h0001;
		end
	end

	// Excitation phase: 512 steps per excitation cycle, restarted on every fdiv-th phase edge
	logic [2:0] fdiv;
	logic [19:0] denom;
	logic [19:0] acc_up;
	logic [3:0] step;
	localparam int RX_STEP_LIMIT = 8;
	assign fdiv = rx_freq_div(exc_ctrl[RX_FREQ_LSB-RX_EXC_USED_LSB +: 2]); // see RQ6
	assign denom = 20'(period) * 20'(fdiv);

	// At most eight steps per clk: period times divisor must reach 64 clk or the wave lags
	always_comb begin
		acc_up = acc + RX_STEPS_PER_CYCLE;
		step = 4'h0;
		for (int i = 0; i < RX_STEP_LIMIT; i++) begin
			if (acc_up >= denom) begin
				acc_up = acc_up - denom;
				step = step + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_idx <= 3'h0;
			acc <= 20'h00000;
			base <= 9'h000;
		end else if (phase_rise && ph_idx >= fdiv - 3'h1) begin
			ph_idx <= 3'h0;
			acc <= 20'h00000;
			base <= 9'h000;
		end else begin
			if (phase_rise)
				ph_idx <= ph_idx + 3'h1;
			acc <= acc_up;
			base <= base + 9'(step);
		end
	end

	// One waveform for all channels, shifted and scaled by the shared control
	logic [8:0] exc_ang;
	logic signed [15:0] exc_raw;
	logic signed [18:0] exc_scaled;
	assign exc_ang = base + {1'b0, exc_ctrl[RX_SHIFT_LSB-RX_EXC_USED_LSB +: 8]}; // see RQ3
	assign exc_raw = rx_sine(exc_ang);
	assign exc_scaled = exc_raw * $signed({2'b00, exc_ctrl[RX_GAIN_LSB-RX_EXC_USED_LSB +: 2]}
		+ 4'h1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			exc_out <= 16'sh0000;
		else
			exc_out <= exc_scaled[17:2]; // see RQ2 see RQ5
	end

	// Compensated inputs and magnitude of the selected channel
	logic signed [15:0] comp_s, comp_c;
	logic [32:0] sq_sum;
	logic signed [31:0] sq_s, sq_c;
	logic [17:0] sos_wide;
	assign comp_s = rx_sat_add(samp[ch].sine, sin_off[ch][15:0]); // see RQ9
	assign comp_c = rx_sat_add(samp[ch].cosine, cos_off[ch][15:0]); // see RQ9
	assign sq_s = comp_s * comp_s;
	assign sq_c = comp_c * comp_c;
	assign sq_sum = 33'($unsigned(sq_s)) + 33'($unsigned(sq_c));
	assign sos_wide = sq_sum[RX_SOS_SHIFT +: 18];

	// Iterative vectoring engine shared by the four channels, 16 cycles each
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= RX_IDLE;
			ch <= 2'h0;
			it <= 4'h0;
			cx <= 20'sh00000;
			cy <= 20'sh00000;
			cz <= 16'h0000;
			sos_hold <= 16'h0000;
		end else begin
			case (state)
				RX_IDLE: begin
					if (phase_rise) begin
						state <= RX_LOAD;
						ch <= 2'h0;
					end
				end
				RX_LOAD: begin
					// Fold the left half-plane over so the iterations converge
					cx <= (comp_c[15] ? -20'(comp_c) : 20'(comp_c)) <<< RX_GUARD_BITS;
					cy <= (comp_c[15] ? -20'(comp_s) : 20'(comp_s)) <<< RX_GUARD_BITS;
					cz <= comp_c[15] ? RX_HALF_TURN : 16'h0000;
					sos_hold <= (sos_wide[17:16] != 2'h0) ? 16'hFFFF : sos_wide[15:0]; // see RQ7
					it <= 4'h0;
					state <= RX_ITER;
				end
				RX_ITER: begin
					if (!cy[19]) begin
						cx <= cx + (cy >>> it);
						cy <= cy - (cx >>> it);
						cz <= cz + RX_ATAN[it];
					end else begin
						cx <= cx - (cy >>> it);
						cy <= cy + (cx >>> it);
						cz <= cz - RX_ATAN[it];
					end
					if (it == 4'(RX_CORDIC_STEPS - 1))
						state <= RX_STORE;
					else
						it <= it + 4'h1;
				end
				RX_STORE: begin
					if (ch == 2'(RX_CHANNELS - 1)) begin
						state <= RX_IDLE;
					end else begin
						ch <= ch + 2'h1;
						state <= RX_LOAD;
					end
				end
				default: state <= RX_IDLE;
			endcase
		end
	end

	// Angle and magnitude written in one edge so a read never splits them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < RX_CHANNELS; i++)
				result[i] <= 32'h0000_0000;
			loss <= '0;
		end else if (state == RX_STORE) begin
			result[ch] <= {enc_ctrl[ch][RX_DIR_BIT] ? angle : -angle, sos_hold}; // see RQ8 see RQ10 see RQ11 see RQ16
			loss[ch] <= (sos_hold[15:12] == 4'h0); // see RQ12
		end
	end

	always_comb begin
		irq_set = 5'h00;
		if (state == RX_STORE) begin
			irq_set[ch] = (sos_hold[15:12] == 4'h0) && !loss[ch];
			irq_set[RX_IRQ_DONE_BIT] = (ch == 2'(RX_CHANNELS - 1));
		end
	end

	// APB decode
	assign setup = psel & ~penable;
	assign access = psel & penable & pready;
	assign wr = access & pwrite & ~pslverr;
	assign rd = access & ~pwrite;
	assign a_chan = (paddr[11:RX_CH_SEL_LSB] == RX_CH_SEL);
	assign a_ch = paddr[RX_CH_IDX_LSB +: 2];
	assign a_reg = paddr[4:0];

	always_comb begin
		next_rdata = 32'h0000_0000;
		next_err = 1'b0;
		if (paddr == RX_ADDR_EXC)
			next_rdata = {exc_ctrl, 20'h00000}; // see RQ1
		else if (paddr == RX_ADDR_IRQ_STAT)
			next_rdata = {27'h0, irq_stat};
		else if (paddr == RX_ADDR_IRQ_MASK)
			next_rdata = {27'h0, irq_mask};
		else if (a_chan) begin
			case (a_reg)
				RX_REG_ENC: next_rdata = enc_ctrl[a_ch];
				RX_REG_SOFF: next_rdata = sin_off[a_ch];
				RX_REG_COFF: next_rdata = cos_off[a_ch];
				RX_REG_RESULT: next_rdata = result[a_ch]; // see RQ14
				RX_REG_STATUS: next_rdata = {loss[a_ch], 31'h0}; // see RQ15
				RX_REG_SOS: next_rdata = {16'h0000, result[a_ch][15:0]}; // see RQ14
				default: next_err = 1'b1;
			endcase
		end else begin
			next_err = 1'b1;
		end
	end

	// Read data latched in the setup cycle; access completes with no wait state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : next_rdata;
				pslverr <= next_err;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exc_ctrl <= RX_EXC_RESET;
			irq_mask <= 5'h00;
			for (int i = 0; i < RX_CHANNELS; i++) begin
				enc_ctrl[i] <= RX_ENC_RESET;
				sin_off[i] <= 32'h0000_0000;
				cos_off[i] <= 32'h0000_0000;
			end
		end else if (wr) begin
			if (paddr == RX_ADDR_EXC)
				exc_ctrl <= pwdata[31:RX_EXC_USED_LSB]; // see RQ1
			else if (paddr == RX_ADDR_IRQ_MASK)
				irq_mask <= pwdata[4:0];
			else if (a_chan && a_reg == RX_REG_ENC)
				enc_ctrl[a_ch] <= pwdata;
			else if (a_chan && a_reg == RX_REG_SOFF)
				sin_off[a_ch] <= pwdata;
			else if (a_chan && a_reg == RX_REG_COFF)
				cos_off[a_ch] <= pwdata;
		end
	end

	// Only bits actually returned are cleared, and a new event wins over the clear
	assign rd_snap = (rd && paddr == RX_ADDR_IRQ_STAT) ? prdata[4:0] : 5'h00;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat <= 5'h00;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~rd_snap) | irq_set;
			irq <= |(irq_stat & irq_mask);
		end
	end

endmodule

// ### rx_checker.sv
// Checker for the resolver interface: bus answers, excitation bound and interrupt release.
`timescale 1ns/1ps
module rx_checker import rx_pkg::*; (
	input wire logic clk, // System clock
	input wire logic arst_n, // Reset, active low
	input wire logic [11:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic phase_clk, // Phase clock
	input wire rx_adc_pair_t [RX_CHANNELS-1:0] adc_in, // ADC codes
	input wire logic signed [15:0] exc_out, // Excitation sample
	input wire logic irq // Interrupt
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic acc;
	logic clr;
	logic [11:0] exc_q;
	logic [1:0] gain_q;
	logic [3:0] age;
	logic [15:0] mag;
	logic [16:0] lim;
	assign acc = psel && penable && pready;
	assign mag = exc_out[15] ? 16'(-exc_out) : exc_out;
	// Small slack for rounding in the amplitude scaling
	assign lim = 17'((gain_q + 3'h1) * 17'h7FD8 / 4 + 2);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clr <= 1'b0;
		end else begin
			clr <= acc && (paddr == RX_ADDR_IRQ_STAT && !pwrite || paddr == RX_ADDR_IRQ_MASK && pwrite);
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			exc_q <= RX_EXC_RESET;
			gain_q <= 2'h0;
			age <= 4'h0;
		end else if (acc && pwrite && paddr == RX_ADDR_EXC) begin
			exc_q <= pwdata[31:20];
			gain_q <= pwdata[23:22];
			age <= 4'h0;
		end else if (age != 4'hF) begin
			age <= age + 4'h1;
		end
	end
	sequence s_setup(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence
	sequence s_xfer;
		psel && !penable ##1 psel && penable;
	endsequence
	property p_exc_used; s_setup(RX_ADDR_EXC) |=> prdata[31:20] == exc_q; endproperty
	a_exc_used: assert property (p_exc_used) else $error("control field readback");
	property p_exc_unused; s_setup(RX_ADDR_EXC) |=> prdata[19:0] == 20'h0; endproperty
	a_exc_unused: assert property (p_exc_unused) else $error("unused bits not zero");
	property p_bad_addr; s_setup(12'h00C) |=> pslverr && prdata == 32'h0; endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unmapped read answer");
	property p_good_addr; s_setup(RX_ADDR_EXC) |=> !pslverr; endproperty
	a_good_addr: assert property (p_good_addr) else $error("error on mapped read");
	property p_ready; psel && penable |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("access not ready");
	property p_stand; s_xfer |=> $stable(prdata) && $stable(pslverr); endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
	property p_gain; age == 4'hF |-> mag <= lim; endproperty
	a_gain: assert property (p_gain) else $error("excitation above magnitude");
	property p_irq_fall; $fell(irq) |-> $past(clr) || $past(clr, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell unasked");
endmodule
bind rx_resolver rx_checker u_chk (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .phase_clk(phase_clk), .adc_in(adc_in), .exc_out(exc_out), .irq(irq));

// ### rx_partner.sv
// Resolver model: free-running phase clock and sine/cosine ADC codes.
`timescale 1ns/1ps
module rx_partner import rx_pkg::*; #(
	parameter int HALF_NS = 500
) (
	input wire rx_adc_pair_t [RX_CHANNELS-1:0] target, // Codes the windings should give
	output logic phase_clk, // Phase clock
	output rx_adc_pair_t [RX_CHANNELS-1:0] adc_in // ADC codes to the device
);
	initial begin
		phase_clk = 1'b0;
		adc_in = '0;
		forever begin
			#(HALF_NS);
			phase_clk = ~phase_clk;
			// Codes move only after the fall, so every rising-edge sample is settled
			if (!phase_clk)
				adc_in = target;
		end
	end
endmodule

// ### rx_resolver_tb_top.sv
// Self-checking bench for the resolver interface.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rx_resolver_tb_top import rx_pkg::*;;
	logic clk, arst_n, psel, penable, pwrite, pready, pslverr, phase_clk, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [15:0] exc_out;
	rx_adc_pair_t [RX_CHANNELS-1:0] adc_in, target;
	int miscompares, tests_run;
	rx_resolver dut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.phase_clk(phase_clk), .adc_in(adc_in), .exc_out(exc_out), .irq(irq));
	rx_partner model (.target(target), .phase_clk(phase_clk), .adc_in(adc_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [11:0] cha(input int k, input logic [4:0] r);
		return {RX_CH_SEL, 2'(k), r};
	endfunction
	function automatic logic [15:0] exp_sos(input int s, input int c);
		longint q;
		q = (longint'(s) * s + longint'(c) * c) >>> 15;
		return (q > 65535) ? 16'hFFFF : 16'(q);
	endfunction
	function automatic logic [15:0] exp_ang(input int s, input int c, input logic dir);
		real a;
		int v;
		a = $atan2(s, c) * 65536.0 / 6.283185307179586;
		v = $rtoi(a < 0.0 ? a + 65536.5 : a + 0.5);
		return dir ? 16'(v) : 16'(-v);
	endfunction
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		results();
	end
	initial begin
		int seed, amp, so, co;
		int sv[4], cv[4];
		real th;
		logic [31:0] v;
		logic [3:0] dir, loss, prev, nl;
		logic [15:0] sq, ga;
		logic [15:0] pk;
		logic [15:0] ex [2];
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		target = '0;
		seed = $urandom(51);
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, RX_ADDR_EXC, 32'h0);
		`CHK(rd, 32'h0)
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, cha(k, RX_REG_ENC), 32'h0);
			`CHK(rd, RX_ENC_RESET)
		end
		apb(1'b0, 12'h00C, 32'h0);
		`CHK({err, rd}, 33'h1_0000_0000)
		for (int g = 0; g < 4; g++) begin
			v = {8'($urandom), 2'(g), 2'(3 - g), 20'($urandom)};
			apb(1'b1, RX_ADDR_EXC, v);
			apb(1'b0, RX_ADDR_EXC, 32'h0);
			`CHK(rd, {v[31:20], 20'h0})
			repeat (40) @(posedge clk);
		end
		// Quarter-cycle shift puts each restart on the crest; halved rate flips sign in between
		pk = RX_QSINE[255 -: 16] >> 1;
		apb(1'b1, RX_ADDR_EXC, {8'h80, 2'h1, 2'h1, 20'h0});
		repeat (2) @(posedge phase_clk);
		for (int n = 0; n < 2; n++) begin
			@(posedge phase_clk);
			repeat (5) @(posedge clk);
			ex[n] = exc_out;
		end
		`CHK(16'(ex[0] + ex[1]), 16'h0)
		`CHK(ex[0] == pk || ex[1] == pk, 1'b1)
		// Idle inputs read as zero, so every channel has entered loss by now
		apb(1'b0, RX_ADDR_IRQ_STAT, 32'h0);
		`CHK(rd[4:0], 5'h1F)
		prev = 4'hF;
		for (int r = 0; r < 6; r++) begin
			apb(1'b1, RX_ADDR_IRQ_MASK, r[0] ? 32'h0F : 32'h0);
			for (int k = 0; k < 4; k++) begin
				dir[k] = 1'($urandom);
				// Ceiling keeps the magnitude below ADC saturation
				amp = (r == 1 && k == 3) ? 0 : (r == 0 ? 'h7000 : $urandom_range('h7000, 'h200));
				th = real'($urandom_range(4095)) * 6.283185307179586 / 4096.0;
				sv[k] = $rtoi(amp * $sin(th));
				cv[k] = $rtoi(amp * $cos(th));
				so = int'($urandom_range(126)) - 63;
				co = int'($urandom_range(126)) - 63;
				apb(1'b1, cha(k, RX_REG_SOFF), 32'(so));
				apb(1'b1, cha(k, RX_REG_COFF), 32'(co));
				apb(1'b1, cha(k, RX_REG_ENC), {29'h0, dir[k], 2'b11});
				target[k] <= '{sine: 16'(sv[k] - so), cosine: 16'(cv[k] - co)};
			end
			repeat (400) @(posedge clk);
			for (int k = 0; k < 4; k++) begin
				sq = exp_sos(sv[k], cv[k]);
				apb(1'b0, cha(k, RX_REG_RESULT), 32'h0);
				v = rd;
				`CHK(v[15:0], sq)
				ga = v[31:16] - exp_ang(sv[k], cv[k], dir[k]);
				`CHK(ga + 16'h20 <= 16'h40, 1'b1)
				apb(1'b0, cha(k, RX_REG_SOS), 32'h0);
				`CHK(rd[15:0], v[15:0])
				apb(1'b0, cha(k, RX_REG_STATUS), 32'h0);
				`CHK(rd[31], sq[15:12] == 4'h0)
				loss[k] = sq[15:12] == 4'h0;
			end
			nl = loss & ~prev;
			`CHK(irq, r[0] & (nl != 4'h0))
			apb(1'b0, RX_ADDR_IRQ_STAT, 32'h0);
			`CHK(rd[4:0], {1'b1, nl})
			repeat (3) @(posedge clk);
			`CHK(irq, 1'b0)
			prev = loss;
		end
		results();
	end
endmodule
